//--- pcw_pkg.sv
// shared constants, state codes and helpers for the processor control word register bank
package pcw_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] PCW_OFS_ERR_MASK = 8'h00;
  localparam logic [7:0] PCW_OFS_CTRL = 8'h04;
  localparam logic [7:0] PCW_OFS_STATUS = 8'h08;

  // control word field positions
  localparam int PCW_B_WAITGEN_EN = 0;
  localparam int PCW_A_WAITGEN_EN = 1;
  localparam int PCW_B_COUNT_LO = 2;
  localparam int PCW_A_COUNT_LO = 4;
  localparam int PCW_PORT_LOW_DIR = 6;
  localparam int PCW_PORT_HIGH_DIR = 7;
  localparam int PCW_GRANT_SRC = 8;
  localparam int PCW_PENDING = 9;
  localparam int PCW_IRQ_LO = 10;
  localparam int PCW_NUM_IRQ = 6;

  // error mask layout
  localparam int PCW_HALT_LO = 8;
  localparam logic [15:0] PCW_EMR_RSVD = 16'h0d0d;
  localparam logic [7:0] PCW_ESR_HALTABLE = 8'hf2;

  // reset values
  localparam logic [15:0] PCW_CTRL_RESET = 16'h0000;
  localparam logic [15:0] PCW_EMR_RESET = 16'hffff;

  // status bit positions
  localparam int PCW_ST_BUSY = 0;
  localparam int PCW_ST_HALT = 1;
  localparam int PCW_ST_READY = 2;

  // wait-state code for ready-extended accesses
  localparam logic [1:0] PCW_CODE_EXT = 2'h3;
  localparam int PCW_CNT_W = 4;

  // one wait-state is one processor clock period
  localparam int PCW_CLOCK_PERIOD_NS = 20;
  localparam int PCW_WAIT_STATE_NS = 20;
  localparam int PCW_WS_CYCLES_RAW = PCW_WAIT_STATE_NS / PCW_CLOCK_PERIOD_NS;
  localparam int PCW_WS_CYCLES = (PCW_WS_CYCLES_RAW < 1) ? 1 : PCW_WS_CYCLES_RAW;

  // ahb transfer type bit that marks an active transfer
  localparam int PCW_HTRANS_ACTIVE = 1;

  typedef enum logic [0:0] {
    PCW_ST_IDLE = 1'b0,
    PCW_ST_WAIT = 1'b1
  } pcw_state_e;

  // wait-states for a count code; the extended code gives its minimum of two
  function automatic logic [PCW_CNT_W-1:0] pcw_waits(input logic [1:0] code);
    logic [PCW_CNT_W-1:0] w;
    case (code)
      2'h0: w = 4'h1;
      2'h1: w = 4'h2;
      2'h2: w = 4'h3;
      default: w = 4'h2;
    endcase
    return PCW_CNT_W'(w * PCW_CNT_W'(PCW_WS_CYCLES));
  endfunction

endpackage

//--- pcw_wait_gen.sv
// wait-state generator for one external memory access at a time
`timescale 1ns/1ps

module pcw_wait_gen (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // access request
  input wire logic start,
  input wire logic waitgen_en,
  input wire logic [1:0] wait_code,
  input wire logic ready,
  // progress
  output logic busy,
  output logic done
);
  import pcw_pkg::*;

  pcw_state_e state_reg;
  logic [PCW_CNT_W-1:0] cnt_reg;
  logic ext_reg;

  // count down the inserted wait-states, then hold for ready on the extended code
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= PCW_ST_IDLE;
      cnt_reg <= '0;
      ext_reg <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_reg)
        PCW_ST_IDLE: begin
          if (start) begin
            if (!waitgen_en) begin
              done <= 1'b1; // generator off: no wait-states
            end else begin
              cnt_reg <= pcw_waits(wait_code); // [RQ4] [RQ5]
              // code latched here, so a control write mid-access waits for the next one
              ext_reg <= (wait_code == PCW_CODE_EXT); // [RQ12]
              state_reg <= PCW_ST_WAIT;
            end
          end
        end
        PCW_ST_WAIT: begin
          if (cnt_reg > 4'h1) begin
            cnt_reg <= cnt_reg - 4'h1;
          end else if (!ext_reg || ready) begin
            done <= 1'b1; // [RQ4]
            state_reg <= PCW_ST_IDLE;
          end
        end
        default: state_reg <= PCW_ST_IDLE;
      endcase
    end
  end

  assign busy = (state_reg == PCW_ST_WAIT);

endmodule

//--- pcw_regs.sv
// processor control word and error mask registers behind an ahb-lite slave
`timescale 1ns/1ps

// Summary of operation
// [RQ1] Bit 1 enables the partition A wait-state generator and bit 0 that of partition B.
// [RQ2] Bits 3:2 pick the wait-state count for partition B accesses.
// [RQ3] Bits 5:4 pick the wait-state count for partition A accesses.
// [RQ4] Codes 00, 01, 10 give one, two, three waits; 11 gives two then waits for ready.
// [RQ5] Every wait-state lasts one processor clock period.
// [RQ6] Grant source bit 0 passes the arbiter grant; 1 drives the inverted OR of pending bits.
// [RQ7] Bits 15:10 hold one enable per interrupt source, six in all.
// [RQ8] An interrupt source raises a request only while its enable bit is one.
// [RQ9] Halt mask bits 9 and 12..15 mask the error status bit eight lower from halting.
// [RQ10] Reserved error mask bits 8, 10 and 11 always read as one.
// [RQ11] Reset sets every error mask bit to one.
// [RQ12] Control writes act on the next access and interrupt evaluation; reads return them.
module pcw_regs (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // external memory access
  input wire logic ext_access_req,
  input wire logic ext_access_part_b,
  input wire logic sync_ready_in,
  output logic ext_access_busy,
  output logic ext_access_done,
  // memory grant
  input wire logic arb_grant,
  input wire logic ext_pending_int,
  output logic memory_grant_pin,
  // parallel port direction
  output logic port_low_dir,
  output logic port_high_dir,
  // interrupts
  input wire logic [pcw_pkg::PCW_NUM_IRQ-1:0] irq_src,
  output logic [pcw_pkg::PCW_NUM_IRQ-1:0] irq_req,
  // error halting
  input wire logic [7:0] error_status,
  output logic halt_req
);
  import pcw_pkg::*;

  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic [15:0] emr_reg;
  logic [15:0] emr_next;
  logic wr_access_pending_bit_reg;
  logic [7:0] wr_addr_reg;
  logic addr_phase;
  logic [2:0] rdy_sync_reg;
  logic rdy_filt_reg;
  logic wg_start;
  logic wg_en;
  logic [1:0] wg_code;
  logic wg_busy;
  logic [7:0] halt_src;
  logic [2:0] status_bits;

  // an active transfer is taken when the bus is ready
  assign addr_phase = hsel && hready && htrans[PCW_HTRANS_ACTIVE];

  // capture the address phase of a write; data follows one cycle later
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_access_pending_bit_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (hready) begin
      wr_access_pending_bit_reg <= addr_phase && hwrite;
      wr_addr_reg <= haddr;
    end
  end

  // next register values, forwarded so a read right behind a write sees it
  always_comb begin
    ctrl_next = ctrl_reg;
    emr_next = emr_reg;
    if (wr_access_pending_bit_reg && (wr_addr_reg == PCW_OFS_CTRL)) begin
      ctrl_next = hwdata[15:0]; // [RQ12]
    end
    if (wr_access_pending_bit_reg && (wr_addr_reg == PCW_OFS_ERR_MASK)) begin
      emr_next = hwdata[15:0] | PCW_EMR_RSVD; // [RQ10]
    end
  end

  // control word storage
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_reg <= PCW_CTRL_RESET;
    end else begin
      ctrl_reg <= ctrl_next; // [RQ12]
    end
  end

  // error mask storage, all ones after reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      emr_reg <= PCW_EMR_RESET; // [RQ11]
    end else begin
      emr_reg <= emr_next;
    end
  end

  // status word shows the block's own live state
  assign status_bits = {rdy_filt_reg, halt_req, wg_busy};

  // read data for the data phase; unmapped offsets read zero
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_phase && !hwrite) begin
      case (haddr)
        PCW_OFS_CTRL: hrdata <= {16'h0000, ctrl_next}; // [RQ12]
        PCW_OFS_ERR_MASK: hrdata <= {16'h0000, emr_next | PCW_EMR_RSVD}; // [RQ10]
        PCW_OFS_STATUS: hrdata <= {29'h0000_0000, status_bits};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // zero-wait slave, always okay; hsize only ever a full word
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ready pin: three flops, a change counts once the last two agree
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdy_sync_reg <= 3'h0;
      rdy_filt_reg <= 1'b0;
    end else begin
      rdy_sync_reg <= {rdy_sync_reg[1:0], sync_ready_in};
      if (rdy_sync_reg[1] == rdy_sync_reg[2]) begin
        rdy_filt_reg <= rdy_sync_reg[2];
      end
    end
  end

  // pick partition settings; sampled at start so a write acts on the next access
  assign wg_start = ext_access_req && !wg_busy;
  assign wg_en = ext_access_part_b ? ctrl_reg[PCW_B_WAITGEN_EN] // [RQ1]
                                   : ctrl_reg[PCW_A_WAITGEN_EN]; // [RQ1]
  assign wg_code = ext_access_part_b ? ctrl_reg[PCW_B_COUNT_LO +: 2] // [RQ2]
                                     : ctrl_reg[PCW_A_COUNT_LO +: 2]; // [RQ3]

  // the generator latches what it needs when an access is taken, so a control write
  // mid-access acts on the next one; requests while busy are ignored
  pcw_wait_gen u_wait_gen (
    .clock(clock),
    .reset_n(reset_n),
    .start(wg_start),
    .waitgen_en(wg_en),
    .wait_code(wg_code),
    .ready(rdy_filt_reg),
    .busy(wg_busy),
    .done(ext_access_done)
  );

  // busy as a registered copy for the pin side
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ext_access_busy <= 1'b0;
    end else begin
      ext_access_busy <= wg_busy; // [RQ5]
    end
  end

  // memory grant source select
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      memory_grant_pin <= 1'b1;
    end else if (!ctrl_reg[PCW_GRANT_SRC]) begin
      memory_grant_pin <= arb_grant; // [RQ6]
    end else begin
      memory_grant_pin <= ~(ctrl_reg[PCW_PENDING] | ext_pending_int); // [RQ6]
    end
  end

  // port directions follow the control word
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      port_low_dir <= 1'b0;
      port_high_dir <= 1'b0;
    end else begin
      port_low_dir <= ctrl_reg[PCW_PORT_LOW_DIR];
      port_high_dir <= ctrl_reg[PCW_PORT_HIGH_DIR];
    end
  end

  // interrupt gating, one enable per source
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_req <= '0;
    end else begin
      irq_req <= irq_src & ctrl_reg[PCW_IRQ_LO +: PCW_NUM_IRQ]; // [RQ7] [RQ8]
    end
  end

  // only the haltable status bits count; reserved positions are dropped
  assign halt_src = error_status & ~emr_reg[PCW_HALT_LO +: 8] & PCW_ESR_HALTABLE; // [RQ9]

  // halt request from any unmasked error
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      halt_req <= 1'b0;
    end else begin
      halt_req <= |halt_src; // [RQ9]
    end
  end

endmodule

//--- pcw_regs_props.sv
// assertion checker for the control word register bank
`timescale 1ns/1ps
module pcw_regs_props import pcw_pkg::*; (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // bus side
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // access, grant, interrupts, halt
  input wire logic sync_ready_in,
  input wire logic ext_access_busy,
  input wire logic ext_access_done,
  input wire logic arb_grant,
  input wire logic ext_pending_int,
  input wire logic memory_grant_pin,
  input wire logic [pcw_pkg::PCW_NUM_IRQ-1:0] irq_src,
  input wire logic [pcw_pkg::PCW_NUM_IRQ-1:0] irq_req,
  input wire logic [7:0] error_status,
  input wire logic halt_req
);
  // one domain, so clock and reset are given once
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_irq; |irq_req |-> (irq_req & ~$past(irq_src)) == 6'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq without source");
  property p_halt; halt_req |-> ($past(error_status) & 8'hf2) != 8'h00; endproperty
  a_halt: assert property (p_halt) else $error("halt without error");
  property p_ok; hreadyout && !hresp; endproperty
  a_ok: assert property (p_ok) else $error("bus not ready or error");
  property p_rsvd; hsel && hready && htrans[1] && !hwrite && haddr == PCW_OFS_ERR_MASK
    |=> hrdata[8] && hrdata[10] && hrdata[11]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved mask bit low");
  property p_rst; $rose(reset_n) |-> memory_grant_pin && !halt_req && irq_req == 6'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  property p_busy; $fell(ext_access_busy) |-> $past(ext_access_done); endproperty
  a_busy: assert property (p_busy) else $error("busy ended without done");
  // with ready settled high no access, the ready-extended code included, runs past three waits
  property p_dlen; sync_ready_in[*6] ##0 $rose(ext_access_busy) |-> ##[0:2] ext_access_done;
  endproperty
  a_dlen: assert property (p_dlen) else $error("access too long");
  property p_grant; $rose(memory_grant_pin) |-> $past(arb_grant) || !$past(ext_pending_int);
  endproperty
  a_grant: assert property (p_grant) else $error("grant pin rose wrongly");
  c_halt: cover property (halt_req);
  c_slow: cover property (ext_access_busy[*6]);
  c_grant: cover property ($fell(memory_grant_pin));
endmodule
bind pcw_regs pcw_regs_props u_pcw_regs_props (.*);

//--- pcw_mem_model.sv
// far-side memory model driving the ready line of external accesses
`timescale 1ns/1ps
module pcw_mem_model #(parameter int SLOW = 6) (
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // access progress and pacing
  input wire logic busy,
  input wire logic slow,
  output logic ready
);
  int cnt_reg;
  // a slow part holds ready low ahead of time, as the sync filter lags
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= 0;
      ready <= 1'b1;
    end else begin
      cnt_reg <= busy ? cnt_reg + 1 : 0;
      ready <= !slow || cnt_reg >= SLOW;
    end
  end
endmodule

//--- testbench.sv
// self-checking bench for the control word register bank
`timescale 1ns/1ps
module testbench;
  import pcw_pkg::*;
  logic clock, reset_n, hsel, hwrite, hready, hreadyout, hresp, slow, arb_grant;
  logic ext_access_req, ext_access_part_b, sync_ready_in, ext_access_busy, ext_access_done;
  logic ext_pending_int, memory_grant_pin, port_low_dir, port_high_dir, halt_req;
  logic [7:0] haddr, error_status;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic [15:0] v;
  logic [5:0] irq_src, irq_req;
  int n_mismatch, total_checks, n;
  assign hready = hreadyout;
  pcw_regs u_pcw_regs (.*);
  pcw_mem_model u_pcw_mem_model (.clock(clock), .reset_n(reset_n), .busy(ext_access_busy),
    .slow(slow), .ready(sync_ready_in));
  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clock); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // registered outputs need a couple of cycles after a write
  task automatic st;
    repeat (3) @(negedge clock);
  endtask
  // one access; n counts cycles from the taking edge to done
  task automatic acc(input logic pb);
    @(posedge clock);
    ext_access_part_b <= pb;
    ext_access_req <= 1'b1;
    @(posedge clock);
    ext_access_req <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (ext_access_done !== 1'b1 && n < 50);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    end_of_test();
  end
  // reset, then the tests in turn
  initial begin
    {reset_n, hsel, hwrite, slow, arb_grant, ext_access_req, ext_access_part_b} = '0;
    {ext_pending_int, haddr, error_status, htrans, hwdata, irq_src} = '0;
    hsize = 3'h2;
    n_mismatch = 0;
    total_checks = 0;
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    bus(1'b0, PCW_OFS_ERR_MASK, 32'h0);
    chk("mask reset", rd, 32'hffff);
    bus(1'b0, PCW_OFS_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    chk("unmapped", rd, 32'h0);
    bus(1'b1, PCW_OFS_ERR_MASK, 32'h0);
    bus(1'b0, PCW_OFS_ERR_MASK, 32'h0);
    chk("mask reserved", rd, 32'hd0d);
    // status: filtered ready long settled high, no halt, generator idle
    bus(1'b0, PCW_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h1 << PCW_ST_READY);
    $display("test registers done");
    @(posedge clock) error_status <= 8'hff;
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, PCW_OFS_ERR_MASK, 32'hffff ^ (32'h100 << i));
      st();
      chk("halt", halt_req, (32'hf2 >> i) & 32'h1);
    end
    $display("test halt done");
    @(posedge clock) irq_src <= 6'h2b;
    for (int j = 0; j < 2; j++) begin
      v = j ? 16'h5400 : 16'hfcc0;
      bus(1'b1, PCW_OFS_CTRL, {16'h0, v});
      st();
      chk("irq", irq_req, v[15:10] & 6'h2b);
      chk("port dir", {port_high_dir, port_low_dir}, v[7:6]);
      bus(1'b0, PCW_OFS_CTRL, 32'h0);
      chk("ctrl", rd, v);
    end
    $display("test irq done");
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, PCW_OFS_CTRL, {22'h0, i[3:2], 8'h0});
      arb_grant <= i[1];
      ext_pending_int <= i[0];
      st();
      chk("grant", memory_grant_pin, i[2] ? !(i[3] | i[0]) : i[1]);
    end
    $display("test grant done");
    for (int i = 0; i < 16; i++) begin
      v = i[0] ? {12'h0, i[3:2], 1'b0, i[1]} : {10'h0, i[3:2], 2'h0, i[1], 1'b0};
      bus(1'b1, PCW_OFS_CTRL, {16'h0, v});
      acc(i[0]);
      chk("wait cycles", n, !i[1] ? 1 : (i[3:2] == 2'h3) ? 3 : i[3:2] + 2);
    end
    // slow memory: ready held low stretches the extended code
    @(posedge clock) slow <= 1'b1;
    bus(1'b1, PCW_OFS_CTRL, 32'h32);
    repeat (8) @(posedge clock);
    acc(1'b0);
    chk("ready extended", n > 5 && n < 50, 32'h1);
    $display("test access done");
    end_of_test();
  end
endmodule
